//--- ptc_pkg.sv
//
// Function
// - three separately programmed 16-bit counters, counting input clocks from DC to 5 MHz
// - six operating modes per counter, chosen by a control byte
// - four byte ports: offsets 0..2 count bytes, offset 3 control byte
// - control bits 7..6 select counter 0, 1 or 2; value 3 illegal
// - bits 5..4: latch, low byte only, high byte only, low then high
// - bits 3..1 pick modes 0..5; top bit ignored for modes 2 and 3
// - bit 0: binary 0..65535 or four-digit decimal 0..9999 counting
// - modes: terminal count, one-shot, rate, square wave, soft and hard strobe
// - counters 1 and 2 chained, output of one clocks the other
// - cascade runs from 2 MHz; fastest rate 2 MHz/4, slowest /65536/65536
// - counter 0 clock, gate and output go to the external connector
// - timer output is an interrupt source only while block transfer is off
// - pacer starts conversions only if external select 0 and internal 1
//
package ptc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ      = 40_000_000;
  localparam int unsigned PACER_SRC_HZ  = 2_000_000;
  localparam int unsigned PACER_DIV     = CLOCK_HZ / PACER_SRC_HZ;
  localparam int unsigned CHANNELS      = 3;

  // ----------------------------------------------------------------
  // ports and control byte fields
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_CONTROL   = 2'h3;
  localparam int unsigned SEL_POS       = 6;
  localparam int unsigned FMT_POS       = 4;
  localparam int unsigned MODE_POS      = 1;
  localparam int unsigned BCD_POS       = 0;
  localparam logic [1:0] SEL_ILLEGAL    = 2'h3;
  localparam logic [1:0] FMT_LATCH      = 2'h0;
  localparam logic [1:0] FMT_LOW        = 2'h1;
  localparam logic [1:0] FMT_HIGH       = 2'h2;
  localparam logic [1:0] FMT_BOTH       = 2'h3;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_TC_EVENT  = 3'h0;
  localparam logic [2:0] MODE_ONE_SHOT  = 3'h1;
  localparam logic [2:0] MODE_RATE      = 3'h2;
  localparam logic [2:0] MODE_SQUARE    = 3'h3;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;

  typedef struct packed {
    logic [1:0] fmt;
    logic [2:0] mode;
    logic       bcd;
  } ptc_cfg_type;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam ptc_cfg_type CFG_RESET     = '{FMT_BOTH, MODE_TC_EVENT, 1'b0};
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [7:0]  DATA_RESET    = 8'h00;

endpackage

//--- ptc_decrement.sv
`timescale 1ns/10ps
// binary or four-digit decimal subtract of 1 or 2, wrapping through zero
module ptc_decrement #(
  parameter int unsigned DIGITS = 4
) (
  input  wire logic [4*DIGITS-1:0] value_i,
  input  wire logic                bcd_i,
  input  wire logic [1:0]          step_i,
  output      logic [4*DIGITS-1:0] result_o
);

  logic [4:0] diff;
  logic       borrow;

  always_comb begin
    diff   = 5'h00;
    borrow = 1'b0;
    if (!bcd_i) begin
      result_o = value_i - {{(4*DIGITS-2){1'b0}}, step_i};
    end else begin
      result_o = '0;
      for (int d = 0; d < DIGITS; d++) begin
        // a borrowed digit wraps 0 -> 9 by adding ten modulo sixteen
        diff = {1'b0, value_i[4*d+:4]} - {4'h0, borrow}
             - ((d == 0) ? {3'h0, step_i} : 5'h00);
        borrow = diff[4];
        result_o[4*d+:4] = borrow ? diff[3:0] + 4'hA : diff[3:0];
      end
    end
  end

endmodule

//--- ptc_timer.sv
`timescale 1ns/10ps
module ptc_timer #(
  parameter int unsigned DIV = ptc_pkg::PACER_DIV
) (
  // clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       ARST_N_I,
  // host byte ports
  input  wire logic [1:0] ADDR_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] DATA_I,
  output      logic [7:0] DATA_O,
  // counter 0 on the connector
  input  wire logic       CNT0_CLK_I,
  input  wire logic       GATE0_I,
  output      logic       OUT0_O,
  // trigger and interrupt routing
  input  wire logic       EXTERNAL_TRIGGER_SELECT_I,
  input  wire logic       INTERNAL_TRIGGER_SELECT_I,
  input  wire logic       TIMER_IRQ_SELECT_I,
  input  wire logic       BLOCK_TRANSFER_ENABLE_I,
  output      logic       PACER_TRIG_O,
  output      logic       TIMER_IRQ_O
);

  localparam int unsigned N = ptc_pkg::CHANNELS;

  ptc_pkg::ptc_cfg_type cfg [N];
  logic [15:0]          count [N];
  logic [15:0]          next_count [N];
  logic [15:0]          reload [N];
  logic [15:0]          snap [N];
  logic [N-1:0]         latched;
  logic [N-1:0]         wr_hi;
  logic [N-1:0]         rd_hi;
  logic [N-1:0]         pending;
  logic [N-1:0]         armed;
  logic [N-1:0]         strobe;
  logic [N-1:0]         out;
  logic [N-1:0]         trig;
  logic [N-1:0]         gate;
  logic [N-1:0]         gate_q;
  logic [N-1:0]         tick;
  logic [N-1:0]         ctl_for;
  logic [N-1:0]         wr_cnt;
  logic [N-1:0]         rd_cnt;
  logic                 clk0_q;
  logic                 out1_q;
  logic                 out2_q;
  logic [7:0]           div_cnt;
  logic                 src_pulse;
  logic [7:0]           src_gap;
  logic                 is_latch;
  logic [2:0]           new_mode;
  logic [15:0]          rd_src;

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  assign is_latch = DATA_I[ptc_pkg::FMT_POS+:2] == ptc_pkg::FMT_LATCH;
  // mode bit 2 is a don't-care once bit 1 is set
  assign new_mode = DATA_I[ptc_pkg::MODE_POS+1] ?
                    {1'b0, DATA_I[ptc_pkg::MODE_POS+:2]} :
                    DATA_I[ptc_pkg::MODE_POS+:3];

  // ----------------------------------------------------------------
  // count sources
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_cnt   <= 8'h00;
      src_pulse <= 1'b0;
    end else if (div_cnt == 8'(DIV - 1)) begin
      div_cnt   <= 8'h00;
      src_pulse <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 8'h01;
      src_pulse <= 1'b0;
    end
  end

  // cycles since the last source pulse, kept apart from the divider
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      src_gap <= 8'h00;
    end else if (src_pulse) begin
      src_gap <= 8'h01;
    end else begin
      src_gap <= src_gap + 8'h01;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      clk0_q <= 1'b0;
      out1_q <= 1'b0;
      out2_q <= 1'b0;
      // gates idle high: a low reset value would fake a trigger edge
      gate_q <= '1;
    end else begin
      clk0_q <= CNT0_CLK_I;
      out1_q <= out[1];
      out2_q <= out[2];
      gate_q <= gate;
    end
  end

  // counters 0 and 2 advance on the falling edge of their clock, counter 1 on each source pulse
  assign tick[0] = clk0_q & ~CNT0_CLK_I;
  assign tick[1] = src_pulse;
  assign tick[2] = out1_q & ~out[1];
  // the pacer pair has no external gate
  assign gate    = {2'b11, GATE0_I};

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_ch
    logic [1:0] step;
    logic       done;
    logic [2:0] md;

    assign md      = cfg[i].mode;
    assign ctl_for[i] = WR_I && ADDR_I == ptc_pkg::PORT_CONTROL &&
                        DATA_I[ptc_pkg::SEL_POS+:2] == 2'(i);
    assign wr_cnt[i]  = WR_I && ADDR_I == 2'(i);
    assign rd_cnt[i]  = RD_I && ADDR_I == 2'(i);
    assign done       = wr_cnt[i] &&
                        (cfg[i].fmt != ptc_pkg::FMT_BOTH || wr_hi[i]);
    // odd square-wave counts step by one once to become even
    assign step = (md == ptc_pkg::MODE_SQUARE && !count[i][0]) ?
                  2'h2 : 2'h1;

    ptc_decrement #(
      .DIGITS (4)
    ) u_dec (
      .value_i  (count[i]),
      .bcd_i    (cfg[i].bcd),
      .step_i   (step),
      .result_o (next_count[i])
    );

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        cfg[i]     <= ptc_pkg::CFG_RESET;
        count[i]   <= ptc_pkg::COUNT_RESET;
        reload[i]  <= ptc_pkg::COUNT_RESET;
        snap[i]    <= ptc_pkg::COUNT_RESET;
        latched[i] <= 1'b0;
        wr_hi[i]   <= 1'b0;
        rd_hi[i]   <= 1'b0;
        pending[i] <= 1'b0;
        armed[i]   <= 1'b0;
        strobe[i]  <= 1'b0;
        out[i]     <= 1'b0;
        trig[i]    <= 1'b0;
      end else if (ctl_for[i] && !is_latch) begin
        cfg[i]     <= '{DATA_I[ptc_pkg::FMT_POS+:2], new_mode,
                        DATA_I[ptc_pkg::BCD_POS]};
        out[i]     <= new_mode != ptc_pkg::MODE_TC_EVENT;
        pending[i] <= 1'b0;
        armed[i]   <= 1'b0;
        strobe[i]  <= 1'b0;
        wr_hi[i]   <= 1'b0;
        rd_hi[i]   <= 1'b0;
        latched[i] <= 1'b0;
      end else begin
        if (tick[i]) begin
          trig[i] <= 1'b0;
        end
        if (gate[i] && !gate_q[i]) begin
          trig[i] <= 1'b1;
        end
        if (tick[i] && strobe[i]) begin
          out[i]    <= 1'b1;
          strobe[i] <= 1'b0;
          armed[i]  <= 1'b0;
        end
        if (tick[i]) begin
          case (md)
            ptc_pkg::MODE_TC_EVENT, ptc_pkg::MODE_SW_STROBE: begin
              if (pending[i]) begin
                count[i]   <= reload[i];
                pending[i] <= 1'b0;
                armed[i]   <= 1'b1;
              end else if (armed[i] && gate[i]) begin
                count[i] <= next_count[i];
                if (count[i] == 16'h0001) begin
                  out[i]    <= md == ptc_pkg::MODE_TC_EVENT;
                  strobe[i] <= md == ptc_pkg::MODE_SW_STROBE;
                end
              end
            end
            ptc_pkg::MODE_ONE_SHOT, ptc_pkg::MODE_HW_STROBE: begin
              if (trig[i]) begin
                count[i] <= reload[i];
                armed[i] <= 1'b1;
                out[i]   <= md != ptc_pkg::MODE_ONE_SHOT;
              end else if (armed[i]) begin
                count[i] <= next_count[i];
                if (count[i] == 16'h0001) begin
                  out[i]    <= md == ptc_pkg::MODE_ONE_SHOT;
                  strobe[i] <= md == ptc_pkg::MODE_HW_STROBE;
                  armed[i]  <= md == ptc_pkg::MODE_HW_STROBE;
                end
              end
            end
            ptc_pkg::MODE_RATE, ptc_pkg::MODE_SQUARE: begin
              if (trig[i] || (pending[i] && !armed[i])) begin
                count[i]   <= reload[i];
                armed[i]   <= 1'b1;
                pending[i] <= 1'b0;
                out[i]     <= 1'b1;
              end else if (armed[i] && gate[i]) begin
                if (count[i] == {14'h0000, step}) begin
                  count[i]   <= reload[i];
                  pending[i] <= 1'b0;
                  out[i]     <= (md == ptc_pkg::MODE_RATE) | ~out[i];
                end else begin
                  count[i] <= next_count[i];
                  if (md == ptc_pkg::MODE_RATE && count[i] == 16'h0002) begin
                    out[i] <= 1'b0;
                  end
                end
              end
            end
            default: begin
              armed[i] <= 1'b0;
            end
          endcase
        end
        // a low gate forces the periodic modes high at once
        if ((md == ptc_pkg::MODE_RATE || md == ptc_pkg::MODE_SQUARE) &&
            !gate[i]) begin
          out[i] <= 1'b1;
        end
        // new count bytes; leaves format ordering to the host
        if (wr_cnt[i]) begin
          case (cfg[i].fmt)
            ptc_pkg::FMT_HIGH: reload[i] <= {DATA_I, 8'h00};
            ptc_pkg::FMT_BOTH: begin
              if (wr_hi[i]) begin
                reload[i][15:8] <= DATA_I;
              end else begin
                reload[i][7:0]  <= DATA_I;
              end
              wr_hi[i] <= ~wr_hi[i];
            end
            default: reload[i] <= {8'h00, DATA_I};
          endcase
        end
        if (done) begin
          pending[i] <= 1'b1;
          if (md == ptc_pkg::MODE_TC_EVENT) begin
            out[i]   <= 1'b0;
            armed[i] <= 1'b0;
          end
        end
        // a repeated latch keeps the first snapshot
        if (ctl_for[i] && !latched[i]) begin
          snap[i]    <= count[i];
          latched[i] <= 1'b1;
          rd_hi[i]   <= 1'b0;
        end
        if (rd_cnt[i]) begin
          if (cfg[i].fmt == ptc_pkg::FMT_BOTH) begin
            rd_hi[i] <= ~rd_hi[i];
          end
          if (cfg[i].fmt != ptc_pkg::FMT_BOTH || rd_hi[i]) begin
            latched[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and outputs
  // ----------------------------------------------------------------
  always_comb begin
    rd_src = count[0];
    for (int k = 0; k < N; k++) begin
      if (ADDR_I == 2'(k)) begin
        rd_src = latched[k] ? snap[k] : count[k];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DATA_O <= ptc_pkg::DATA_RESET;
    end else if (RD_I) begin
      if (ADDR_I == ptc_pkg::PORT_CONTROL) begin
        DATA_O <= ptc_pkg::DATA_RESET;
      end else if (cfg[ADDR_I].fmt == ptc_pkg::FMT_HIGH ||
                   (cfg[ADDR_I].fmt == ptc_pkg::FMT_BOTH && rd_hi[ADDR_I]))
      begin
        DATA_O <= rd_src[15:8];
      end else begin
        DATA_O <= rd_src[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PACER_TRIG_O <= 1'b0;
      TIMER_IRQ_O  <= 1'b0;
    end else begin
      PACER_TRIG_O <= out[2] && !out2_q && !EXTERNAL_TRIGGER_SELECT_I &&
                      INTERNAL_TRIGGER_SELECT_I;
      TIMER_IRQ_O  <= out[0] && TIMER_IRQ_SELECT_I &&
                      !BLOCK_TRANSFER_ENABLE_I;
    end
  end

  assign OUT0_O = out[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_illegal_select: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    WR_I && ADDR_I == ptc_pkg::PORT_CONTROL &&
    DATA_I[7:6] == ptc_pkg::SEL_ILLEGAL
    |=> cfg[0] == $past(cfg[0]) && cfg[1] == $past(cfg[1]) &&
        cfg[2] == $past(cfg[2]))
    else $error("illegal select changed a counter");

  chk_mode_decode: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    ctl_for[1] && !is_latch && DATA_I[2]
    |=> cfg[1].mode == {1'b0, $past(DATA_I[2:1])})
    else $error("mode 2 or 3 decoded wrongly");

  chk_mode0_load: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    wr_cnt[0] && cfg[0].mode == ptc_pkg::MODE_TC_EVENT &&
    cfg[0].fmt == ptc_pkg::FMT_LOW && !ctl_for[0]
    |=> !out[0] && pending[0])
    else $error("mode 0 output not low after load");

  chk_pacer_gate: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    PACER_TRIG_O |-> $past(INTERNAL_TRIGGER_SELECT_I) &&
                     !$past(EXTERNAL_TRIGGER_SELECT_I) && out2_q)
    else $error("pacer trigger while not selected");

  chk_irq_block: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    BLOCK_TRANSFER_ENABLE_I [*2] |-> !TIMER_IRQ_O)
    else $error("timer interrupt during block transfer");

  chk_src_rate: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    src_pulse == (src_gap == 8'(DIV)))
    else $error("2 MHz source period wrong");

  chk_latch_hold: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    latched[0] && !ctl_for[0] |=> snap[0] == $past(snap[0]))
    else $error("latched snapshot moved");

  chk_read_pair: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    rd_cnt[1] && !ctl_for[1] && cfg[1].fmt == ptc_pkg::FMT_BOTH &&
    !rd_hi[1] |=> rd_hi[1] ##0 (latched[1] == $past(latched[1])))
    else $error("low byte read did not advance to high");

  chk_cnt0_edge: assert property (
    @(posedge CLOCK_I) disable iff (!ARST_N_I)
    count[0] != $past(count[0]) && !$past(ctl_for[0])
    |-> $past(clk0_q) && !$past(CNT0_CLK_I))
    else $error("counter 0 moved without a clock edge");

endmodule

//--- ptc_host_model.sv
`timescale 1ns/10ps
module ptc_host_model (
  // clock
  input  wire logic       clk_i,
  // byte ports
  input  wire logic [7:0] rd_data_i,
  output      logic [1:0] addr_o,
  output      logic       wr_o,
  output      logic       rd_o,
  output      logic [7:0] wr_data_o
);
  logic [2:0] cfg_seen;
  int         order_faults;

  initial begin
    addr_o    = 2'h0;
    wr_o      = 1'b0;
    rd_o      = 1'b0;
    wr_data_o = 8'h00;
    cfg_seen  = 3'h0;
    order_faults = 0;
  end

  // ----------------------------------------------------------------
  // byte cycles
  // ----------------------------------------------------------------
  // count access before its control byte is a host fault
  task automatic order_chk(input logic [1:0] addr);
    if (addr != 2'h3 && cfg_seen[addr] !== 1'b1) begin
      $display("ERROR %0t: count access before control byte", $time);
      order_faults++;
    end
  endtask

  task automatic wr_port(input logic [1:0] addr, input logic [7:0] data);
    order_chk(addr);
    @(posedge clk_i);
    addr_o    <= addr;
    wr_data_o <= data;
    wr_o      <= 1'b1;
    @(posedge clk_i);
    wr_o      <= 1'b0;
    // bus carries the inverted byte outside the strobe, never keeps the last byte
    wr_data_o <= ~data;
    if (addr == 2'h3 && data[7:6] != 2'h3) begin
      cfg_seen[data[7:6]] = 1'b1;
    end
  endtask

  task automatic rd_port(input logic [1:0] addr, output logic [7:0] data);
    order_chk(addr);
    @(posedge clk_i);
    addr_o <= addr;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    #1;
    data = rd_data_i;
  endtask
endmodule

//--- test_ptc_timer.sv
`timescale 1ns/10ps
`define CHECK(got, exp, msg) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp); \
    end \
  end
module test_ptc_timer;
  localparam int unsigned DIV = 4;
  logic       clock;
  logic       arst_n;
  logic [1:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       cnt0_clk;
  logic       gate0;
  logic       out0;
  logic       ext_sel;
  logic       int_sel;
  logic       irq_sel;
  logic       blk_en;
  logic       pacer;
  logic       irq;
  int         num_errors;
  int         n_tests;
  int         cyc;

  ptc_timer #(.DIV(DIV)) u_ptc_timer (
    .CLOCK_I                   (clock),
    .ARST_N_I                  (arst_n),
    .ADDR_I                    (addr),
    .WR_I                      (wr),
    .RD_I                      (rd),
    .DATA_I                    (wdata),
    .DATA_O                    (rdata),
    .CNT0_CLK_I                (cnt0_clk),
    .GATE0_I                   (gate0),
    .OUT0_O                    (out0),
    .EXTERNAL_TRIGGER_SELECT_I (ext_sel),
    .INTERNAL_TRIGGER_SELECT_I (int_sel),
    .TIMER_IRQ_SELECT_I        (irq_sel),
    .BLOCK_TRANSFER_ENABLE_I   (blk_en),
    .PACER_TRIG_O              (pacer),
    .TIMER_IRQ_O               (irq)
  );

  ptc_host_model u_ptc_host_model (
    .clk_i     (clock),
    .rd_data_i (rdata),
    .addr_o    (addr),
    .wr_o      (wr),
    .rd_o      (rd),
    .wr_data_o (wdata)
  );

  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wr8(input logic [1:0] a, input logic [7:0] d);
    u_ptc_host_model.wr_port(a, d);
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_ptc_host_model.rd_port(a, got);
    `CHECK(got, exp, "read byte")
  endtask

  // n falling edges on the connector clock, low held 3 cycles, high held 4 between edges
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      cnt0_clk <= 1'b0;
      repeat (3) @(posedge clock);
      cnt0_clk <= 1'b1;
      repeat (3) @(posedge clock);
    end
    #1;
  endtask

  task automatic wait_pulse(output int t);
    t = -1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      #1;
      if (pacer === 1'b1) begin
        t = cyc;
        break;
      end
    end
  endtask

  task automatic count_pulses(output int n);
    n = 0;
    repeat (64) begin
      @(posedge clock);
      #1;
      if (pacer === 1'b1) n++;
    end
  endtask

  task automatic test_done(input string name);
    $display("test %s done, errors so far %0d", name, num_errors);
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int t0;
    int t1;
    int hi;
    int n;
    clock = 1'b0;
    arst_n = 1'b0;
    cnt0_clk = 1'b1;
    gate0 = 1'b1;
    ext_sel = 1'b0;
    int_sel = 1'b1;
    irq_sel = 1'b0;
    blk_en = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    `CHECK({rdata, out0, pacer, irq}, 11'h000, "reset outputs")
    rd_chk(2'h3, 8'h00);
    test_done("reset");

    // terminal count on counter 0, then interrupt routing
    wr8(2'h3, 8'h30);
    wr8(2'h0, 8'h05);
    wr8(2'h0, 8'h00);
    #1;
    `CHECK(out0, 1'b0, "out low after load")
    tick(5);
    `CHECK(out0, 1'b0, "out low at count 1")
    tick(1);
    `CHECK(out0, 1'b1, "out high at zero")
    irq_sel <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    `CHECK(irq, 1'b1, "irq routed")
    blk_en <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    `CHECK(irq, 1'b0, "irq blocked")
    test_done("terminal count");

    // latch snapshot while counting goes on
    wr8(2'h3, 8'h30);
    wr8(2'h0, 8'h34);
    wr8(2'h0, 8'h12);
    tick(3);
    wr8(2'h3, 8'h00);
    tick(1);
    rd_chk(2'h0, 8'h32);
    rd_chk(2'h0, 8'h12);
    rd_chk(2'h0, 8'h31);
    rd_chk(2'h0, 8'h12);
    test_done("latch");

    // decimal count 10 steps to 9
    wr8(2'h3, 8'h31);
    wr8(2'h0, 8'h10);
    wr8(2'h0, 8'h00);
    tick(2);
    rd_chk(2'h0, 8'h09);
    rd_chk(2'h0, 8'h00);
    test_done("decimal");

    // single-byte formats, then an illegal select changes nothing
    wr8(2'h3, 8'h10);
    wr8(2'h0, 8'h07);
    tick(1);
    rd_chk(2'h0, 8'h07);
    rd_chk(2'h0, 8'h07);
    wr8(2'h3, 8'h20);
    wr8(2'h0, 8'h02);
    tick(1);
    rd_chk(2'h0, 8'h02);
    wr8(2'h3, 8'hD0);
    rd_chk(2'h0, 8'h02);
    test_done("formats");

    // every mode code, aliases included: count high samples of out
    for (int i = 0; i < 8; i++) begin
      wr8(2'h3, {4'h3, i[2:0], 1'b0});
      wr8(2'h0, i[1] ? (i[0] ? 8'h04 : 8'h03) : 8'h02);
      wr8(2'h0, 8'h00);
      if (i == 1 || i == 5) begin
        @(posedge clock);
        gate0 <= 1'b0;
        repeat (2) @(posedge clock);
        gate0 <= 1'b1;
      end
      tick(1);
      hi = 0;
      repeat ((i[1] && i[0]) ? 8 : 6) begin
        tick(1);
        if (out0 === 1'b1) hi++;
      end
      `CHECK(hi, i[1] ? 4 : 5, "out high samples")
    end
    test_done("modes");

    // fastest pacer: counters 1 and 2 at count 2 each
    wr8(2'h3, 8'h74);
    // unloaded counter 1 reads zero, pointer walks low then high
    rd_chk(2'h1, 8'h00);
    rd_chk(2'h1, 8'h00);
    wr8(2'h1, 8'h02);
    wr8(2'h1, 8'h00);
    wr8(2'h3, 8'hB4);
    wr8(2'h2, 8'h02);
    wr8(2'h2, 8'h00);
    wait_pulse(t0);
    wait_pulse(t1);
    `CHECK(t1 - t0, 4 * DIV, "pacer period")
    `CHECK(t0 >= 0, 1'b1, "pacer running")
    ext_sel <= 1'b1;
    count_pulses(n);
    `CHECK(n, 0, "pacer off with external")
    ext_sel <= 1'b0;
    int_sel <= 1'b0;
    count_pulses(n);
    `CHECK(n, 0, "pacer off without internal")
    `CHECK(u_ptc_host_model.order_faults, 0, "access order")
    test_done("pacer");
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report;
  end
endmodule
